// ---- hdl/mm_port_defs.svh ----
// constants shared by both ends of the memory-mapped port
`ifndef MM_PORT_DEFS_SVH
`define MM_PORT_DEFS_SVH
`define MM_DATA_W 32
`define MM_ADDR_W 8
`define MM_WORDS 16
`define MM_BYTE_W 8
`define MM_RESET_WORD 32'h0000_0000
`define MM_UNIT_WORD 1'b0
`define MM_UNIT_BYTE 1'b1
`endif

// ---- hdl/mm_port_pkg.sv ----
// types used by the master end of the memory-mapped port
`include "mm_port_defs.svh"
package mm_port_pkg;
   typedef enum logic [1:0]
   {
      M_IDLE = 2'b00,
      M_REQ = 2'b01,
      M_DONE = 2'b11
   } master_state_t;
endpackage

// ---- hdl/mm_port_if.sv ----
// interface joining the requesting master and the slave port
`timescale 1ns/1ns
`include "mm_port_defs.svh"
interface mm_port_if #(
   parameter int DATA_W = `MM_DATA_W,
   parameter int ADDR_W = `MM_ADDR_W
);
   logic [ADDR_W-1:0] address;
   logic [DATA_W/8-1:0] byteenable;
   logic read;
   logic write;
   logic [DATA_W-1:0] writedata;
   logic [DATA_W-1:0] readdata;
   logic readdatavalid;
   modport slave (input address, input byteenable, input read, input write, input writedata,
      output readdata, output readdatavalid);
   modport master (output address, output byteenable, output read, output write, output writedata,
      input readdata, input readdatavalid);
endinterface

// ---- hdl/mm_lane_merge.sv ----
// byte-lane merge of write data into a stored word
`timescale 1ns/1ns
`include "mm_port_defs.svh"
module mm_lane_merge #(
   parameter int DATA_W = `MM_DATA_W
)(
   input wire logic [DATA_W-1:0] old_in,
   input wire logic [DATA_W-1:0] new_in,
   input wire logic [DATA_W/8-1:0] lanes_in,
   output logic [DATA_W-1:0] merged_out
);
   always_comb
   begin
      for (int i = 0; i < DATA_W/`MM_BYTE_W; i++)
      begin
         merged_out[i*`MM_BYTE_W +: `MM_BYTE_W] = lanes_in[i] ? new_in[i*`MM_BYTE_W +: `MM_BYTE_W]
            : old_in[i*`MM_BYTE_W +: `MM_BYTE_W];
      end
   end
endmodule

// ---- hdl/mm_slave_port.sv ----
// slave end: small word store reached over the memory-mapped port
`timescale 1ns/1ns
`include "mm_port_defs.svh"
module mm_slave_port #(
   parameter int DATA_W = `MM_DATA_W,
   parameter int ADDR_W = `MM_ADDR_W,
   parameter int WORDS = `MM_WORDS,
   parameter bit HAS_LANES = 1'b1
)(
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic ADDRESS_UNIT_SETTING_IN,
   mm_port_if.slave bus,
   output logic [DATA_W-1:0] WORD0_OUT
);
   localparam int LANES = DATA_W/8;
   localparam int SHIFT = $clog2(LANES);
   localparam int IW = (WORDS > 1) ? $clog2(WORDS) : 1;
   typedef struct packed
   {
      logic [WORDS-1:0][DATA_W-1:0] mem;
      logic [DATA_W-1:0] rdata;
      logic rvalid;
   } slave_state_t;
   slave_state_t st_r;
   slave_state_t st_nxt;
   logic [DATA_W/8-1:0] lanes;
   logic [IW-1:0] idx;
   logic [DATA_W-1:0] merged;
   logic hit;
   // word index by default, byte address shifted down when byte units chosen
   function automatic logic [ADDR_W-1:0] word_index(input logic [ADDR_W-1:0] a, input logic unit);
      word_index = (unit == `MM_UNIT_BYTE) ? (a >> SHIFT) : a;
   endfunction
   always_comb
   begin
      lanes = HAS_LANES ? bus.byteenable : '1;
      hit = (word_index(bus.address, ADDRESS_UNIT_SETTING_IN) < ADDR_W'(WORDS));
      idx = IW'(word_index(bus.address, ADDRESS_UNIT_SETTING_IN));
   end
   mm_lane_merge #(.DATA_W(DATA_W)) mm_lane_merge_inst (
      .old_in(st_r.mem[idx]),
      .new_in(bus.writedata),
      .lanes_in(lanes),
      .merged_out(merged)
   );
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      if (bus.write && hit)
      begin
         st_nxt.mem[idx] = merged;
      end
      if (bus.read)
      begin
         // reads have no side effect, so the full word returns regardless of lanes
         st_nxt.rdata = hit ? st_r.mem[idx] : '0;
         st_nxt.rvalid = 1'b1;
      end
   end
   always_ff @(posedge CLOCK_IN)
   begin
      if (!RESET_N_IN)
      begin
         for (int i = 0; i < WORDS; i++)
         begin
            st_r.mem[i] <= `MM_RESET_WORD;
         end
         st_r.rdata <= '0;
         st_r.rvalid <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign bus.readdata = st_r.rdata;
   assign bus.readdatavalid = st_r.rvalid;
   assign WORD0_OUT = st_r.mem[0];
endmodule

// ---- hdl/mm_master_port.sv ----
// master end: issues single aligned reads and writes from a user request
`timescale 1ns/1ns
`include "mm_port_defs.svh"
module mm_master_port #(
   parameter int DATA_W = `MM_DATA_W,
   parameter int ADDR_W = `MM_ADDR_W
)(
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic REQ_IN,
   input wire logic WRITE_IN,
   input wire logic [ADDR_W-1:0] ADDR_IN,
   input wire logic [DATA_W/8-1:0] LANES_IN,
   input wire logic [DATA_W-1:0] WDATA_IN,
   output logic BUSY_OUT,
   output logic DONE_OUT,
   output logic [DATA_W-1:0] RDATA_OUT,
   mm_port_if.master bus
);
   typedef struct packed
   {
      mm_port_pkg::master_state_t st;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W/8-1:0] lanes;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic [DATA_W-1:0] rdata;
   } master_reg_t;
   master_reg_t m_r;
   master_reg_t m_nxt;
   // gaps inside the user's lane mask are filled so the bus only ever sees one adjacent group;
   // an empty mask becomes all lanes rather than a transfer that touches nothing
   function automatic logic [DATA_W/8-1:0] lane_group(input logic [DATA_W/8-1:0] l);
      logic [DATA_W/8-1:0] from_low;
      logic [DATA_W/8-1:0] from_high;
      from_low[0] = l[0];
      for (int i = 1; i < DATA_W/8; i++)
      begin
         from_low[i] = from_low[i-1] | l[i];
      end
      from_high[DATA_W/8-1] = l[DATA_W/8-1];
      for (int i = DATA_W/8-2; i >= 0; i--)
      begin
         from_high[i] = from_high[i+1] | l[i];
      end
      lane_group = (l == '0) ? '1 : (from_low & from_high);
   endfunction
   always_comb
   begin
      m_nxt = m_r;
      case (m_r.st)
         mm_port_pkg::M_IDLE:
         begin
            if (REQ_IN)
            begin
               m_nxt.st = mm_port_pkg::M_REQ;
               m_nxt.addr = ADDR_IN;
               m_nxt.lanes = lane_group(LANES_IN);
               m_nxt.wdata = WDATA_IN;
               m_nxt.wr = WRITE_IN;
            end
         end
         mm_port_pkg::M_REQ:
         begin
            if (m_r.wr)
            begin
               m_nxt.st = mm_port_pkg::M_DONE;
            end
            else if (bus.readdatavalid)
            begin
               m_nxt.rdata = bus.readdata;
               m_nxt.st = mm_port_pkg::M_DONE;
            end
         end
         default:
         begin
            m_nxt.st = mm_port_pkg::M_IDLE;
         end
      endcase
   end
   always_ff @(posedge CLOCK_IN)
   begin
      if (!RESET_N_IN)
      begin
         m_r <= '0;
      end
      else
      begin
         m_r <= m_nxt;
      end
   end
   // strobes last one cycle; the slave answers reads one cycle later
   assign bus.address = m_r.addr;
   assign bus.byteenable = m_r.lanes;
   assign bus.writedata = m_r.wdata;
   assign bus.write = (m_r.st == mm_port_pkg::M_REQ) && m_r.wr;
   assign bus.read = (m_r.st == mm_port_pkg::M_REQ) && !m_r.wr && !bus.readdatavalid;
   assign BUSY_OUT = (m_r.st != mm_port_pkg::M_IDLE);
   assign DONE_OUT = (m_r.st == mm_port_pkg::M_DONE);
   assign RDATA_OUT = m_r.rdata;
endmodule

// ---- dv/mm_port_chk.sv ----
// assertions on the wires between the master and slave ends
`timescale 1ns/1ns
`include "mm_port_defs.svh"
module mm_port_chk (
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic [`MM_ADDR_W-1:0] address,
   input wire logic [`MM_DATA_W/8-1:0] byteenable,
   input wire logic read,
   input wire logic write,
   input wire logic [`MM_DATA_W-1:0] readdata,
   input wire logic readdatavalid
);
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RESET_N_IN);
   rd_answer_a: assert property (read |=> readdatavalid) else $error("read not answered");
   valid_cause_a: assert property (readdatavalid |-> $past(read)) else $error("valid without read");
   one_role_a: assert property (!(read && write)) else $error("read and write together");
   rd_pulse_a: assert property (read |=> !read) else $error("read held");
   wr_pulse_a: assert property (write |=> !write) else $error("write held");
   lanes_adj_a: assert property ((read || write) |-> byteenable inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7,
      4'hE, 4'hF}) else $error("lanes not adjacent");
   rd_lanes_a: assert property (read |-> byteenable != 4'h0) else $error("read with no lanes");
   data_hold_a: assert property (!readdatavalid |-> $stable(readdata)) else $error("readdata moved");
   reset_idle_a: assert property (disable iff (1'b0) !RESET_N_IN |=> !readdatavalid && !read && !write)
      else $error("port busy in reset");
   cover property (write && byteenable != 4'hF);
   cover property (read ##1 readdatavalid);
   cover property (write ##2 read);
   cover property (read && byteenable != 4'hF);
endmodule

// ---- dv/tb_mm_slave_port_addressing.sv ----
// self-checking bench joining the master and slave ends
`timescale 1ns/1ns
`include "mm_port_defs.svh"
module tb_mm_slave_port_addressing;
   typedef struct {logic w; logic [7:0] a; logic [3:0] l; logic [31:0] d; logic [31:0] e;} row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic unit = 1'b0;
   logic req = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [3:0] lanes = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic busy;
   logic done;
   logic [31:0] rdata;
   logic [31:0] word0;
   int bad_count = 0;
   int n_tests = 0;
   // writes expect word 0, reads expect the returned word; 8'h14 is past the store
   // lanes 4'h5 are not adjacent: the master widens them to 4'h7 before the bus sees them
   row_t rows [9] = '{'{1'b1, 8'h00, 4'hF, 32'h1122_3344, 32'h1122_3344},
      '{1'b1, 8'h00, 4'h2, 32'hAAAA_BBBB, 32'h1122_BB44}, '{1'b0, 8'h00, 4'h0, 32'h0000_0000, 32'h1122_BB44},
      '{1'b1, 8'h01, 4'hC, 32'h5566_7788, 32'h1122_BB44}, '{1'b0, 8'h01, 4'h1, 32'h0000_0000, 32'h5566_0000},
      '{1'b1, 8'h14, 4'hF, 32'hFFFF_FFFF, 32'h1122_BB44}, '{1'b0, 8'h14, 4'hF, 32'h0000_0000, 32'h0000_0000},
      '{1'b1, 8'h02, 4'h5, 32'hAABB_CCDD, 32'h1122_BB44}, '{1'b0, 8'h02, 4'hF, 32'h0000_0000, 32'h00BB_CCDD}};
   always #20 clk = ~clk;
   mm_port_if mm_port_if_inst ();
   mm_slave_port mm_slave_port_inst (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .ADDRESS_UNIT_SETTING_IN(unit),
      .bus(mm_port_if_inst), .WORD0_OUT(word0));
   mm_master_port mm_master_port_inst (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .REQ_IN(req), .WRITE_IN(wr),
      .ADDR_IN(addr), .LANES_IN(lanes), .WDATA_IN(wdata), .BUSY_OUT(busy), .DONE_OUT(done),
      .RDATA_OUT(rdata), .bus(mm_port_if_inst));
   mm_port_chk mm_port_chk_inst (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .address(mm_port_if_inst.address),
      .byteenable(mm_port_if_inst.byteenable), .read(mm_port_if_inst.read), .write(mm_port_if_inst.write),
      .readdata(mm_port_if_inst.readdata), .readdatavalid(mm_port_if_inst.readdatavalid));
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] l, input logic [31:0] d);
      int k;
      @(negedge clk);
      req = 1'b1;
      wr = w;
      addr = a;
      lanes = l;
      wdata = d;
      @(negedge clk);
      req = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 20)
      begin
         @(negedge clk);
         k++;
      end
      if (done !== 1'b1)
      begin
         bad_count++;
         conclude();
      end
   endtask
   initial
   begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 9; i++)
      begin
         xfer(rows[i].w, rows[i].a, rows[i].l, rows[i].d);
         @(negedge clk);
         chk("row result", rows[i].w ? word0 : rdata, rows[i].e);
         $display("row %0d done", i);
      end
      // byte units drop the low lane bits, so 8'h04 reaches the second word
      unit = 1'b1;
      xfer(1'b0, 8'h04, 4'h8, 32'h0000_0000);
      @(negedge clk);
      chk("byte unit read", rdata, 32'h5566_0000);
      $display("byte unit test done");
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      chk("word0 after reset", word0, `MM_RESET_WORD);
      chk("busy after reset", {31'h0000_0000, busy}, 32'h0000_0000);
      chk("rdata after reset", rdata, 32'h0000_0000);
      xfer(1'b0, 8'h00, 4'hF, 32'h0000_0000);
      @(negedge clk);
      chk("read after reset", rdata, `MM_RESET_WORD);
      $display("reset test done");
      conclude();
   end
endmodule
